// ===== rtl/adc_result_access.sv
// Overview of operation
// - Each 12-bit result kept as two bytes; upper byte holds bits 11..4.
// - Lower byte holds bits 3..0 in 7..4; bits 3..0 reserved, read zero.
// - Channel 0..7 result registers occupy 0x25 through 0x34, two per channel.
// - A write to either result address of an active channel starts its conversion.
// - Finished conversion is stored; reads return the latest completed result.
// - Read of upper address answers one byte: result bits 11..4.
// - Read of lower address answers two bytes: lower first, then upper.
// - Read of a channel that is not an active analog input gets no answer.
// - Write to 0x35 converts every active analog channel in turn.
// - Data byte of a write to 0x35 is ignored.
// - Collective conversion walks channels upward from 0 to 7.
// - Read of 0x35 returns lower, upper per active channel, ascending, max 16.
// - Requests come from local host command mode or remote powerline master.
// - Active analog input means function bit set and direction bit input.
// - Upper register at even slot of the pair, from 0x25; lower next.
`timescale 1ns/1ps

module adc_result_access #(
  parameter int NUM_CH = adc_access_pkg::NUM_CH,
  parameter int RES_W = adc_access_pkg::RES_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register request from the command decoder (local or powerline)
  input wire logic req_valid,
  input wire adc_access_pkg::reg_req_t req,
  output logic req_ready_ff,
  // Response byte stream
  output logic resp_valid_ff,
  output adc_access_pkg::resp_byte_t resp_ff,
  input wire logic resp_ready,
  // Pin configuration from the direction and function registers
  input wire logic [NUM_CH-1:0] io_direction,
  input wire logic [NUM_CH-1:0] io_function,
  // Converter
  output logic conv_start_ff,
  output logic [adc_access_pkg::CH_W-1:0] conv_channel_ff,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result
);

  localparam int CW = adc_access_pkg::CH_W;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] active;
  logic take;
  logic in_results;
  logic is_all;
  logic [7:0] offset;
  logic [CW-1:0] req_ch;
  logic req_lower;

  assign active = io_function & io_direction;
  // Both the local host path and the powerline path feed this one port.
  assign take = req_valid && req_ready_ff;
  assign in_results = (req.addr >= adc_access_pkg::RESULT_BASE_ADDR) &&
                      (req.addr <= adc_access_pkg::RESULT_LAST_ADDR);
  assign is_all = (req.addr == adc_access_pkg::CONVERT_ALL_ADDR);
  assign offset = req.addr - adc_access_pkg::RESULT_BASE_ADDR;
  assign req_ch = offset[CW:1];
  assign req_lower = offset[0];

  function automatic logic [CW-1:0] lowest(input logic [NUM_CH-1:0] m);
    logic [CW-1:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = CW'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Result storage
  // ----------------------------------------------------------------
  logic [7:0] upper_q [NUM_CH];
  logic [7:0] lower_q [NUM_CH];
  adc_access_pkg::conv_state_t conv_state_ff, nxt_conv_state;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_slot
    adc_result_slot #(.RES_W(RES_W)) u_slot (
      .clk(clk),
      .rst(rst),
      .load(conv_done && (conv_state_ff == adc_access_pkg::CONV_WAIT) &&
            (conv_channel_ff == CW'(g))),
      .result(conv_result),
      .upper_ff(upper_q[g]),
      .lower_ff(lower_q[g])
    );
  end

  // ----------------------------------------------------------------
  // Conversion scheduler
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] pend_ff, nxt_pend;
  logic nxt_start;
  logic [CW-1:0] nxt_channel;

  always_comb begin
    nxt_pend = pend_ff;
    nxt_conv_state = conv_state_ff;
    nxt_start = 1'b0;
    nxt_channel = conv_channel_ff;
    case (conv_state_ff)
      adc_access_pkg::CONV_IDLE: begin
        if (|pend_ff) begin
          // Lowest pending first gives the upward walk.
          nxt_channel = lowest(pend_ff);
          nxt_start = 1'b1;
          nxt_conv_state = adc_access_pkg::CONV_WAIT;
        end
      end
      adc_access_pkg::CONV_WAIT: begin
        if (conv_done) begin
          nxt_pend[conv_channel_ff] = 1'b0;
          nxt_conv_state = adc_access_pkg::CONV_IDLE;
        end
      end
      default: begin
        nxt_conv_state = adc_access_pkg::CONV_IDLE;
      end
    endcase
    // New requests applied after the clear, so a request landing on completion is kept
    if (take && req.write) begin
      if (in_results) begin
        nxt_pend[req_ch] = nxt_pend[req_ch] | active[req_ch];
      end
      if (is_all) begin
        nxt_pend = nxt_pend | active;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_ff <= '0;
      conv_state_ff <= adc_access_pkg::CONV_IDLE;
      conv_start_ff <= 1'b0;
      conv_channel_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
      conv_state_ff <= nxt_conv_state;
      conv_start_ff <= nxt_start;
      conv_channel_ff <= nxt_channel;
    end
  end

  // ----------------------------------------------------------------
  // Read responder
  // ----------------------------------------------------------------
  adc_access_pkg::resp_state_t resp_state_ff, nxt_resp_state;
  logic rd_all_ff, nxt_rd_all;
  logic rd_upper_next_ff, nxt_rd_upper_next;
  logic [CW-1:0] rd_ch_ff, nxt_rd_ch;
  logic [7:0] hold_ff, nxt_hold;
  logic nxt_resp_valid;
  logic nxt_req_ready;
  adc_access_pkg::resp_byte_t nxt_resp;
  logic [NUM_CH-1:0] above;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      above[i] = active[i] && (CW'(i) > rd_ch_ff);
    end
  end

  always_comb begin
    nxt_resp_state = resp_state_ff;
    nxt_rd_all = rd_all_ff;
    nxt_rd_upper_next = rd_upper_next_ff;
    nxt_rd_ch = rd_ch_ff;
    nxt_hold = hold_ff;
    nxt_resp_valid = resp_valid_ff;
    nxt_resp = resp_ff;
    nxt_req_ready = req_ready_ff;
    case (resp_state_ff)
      adc_access_pkg::RESP_IDLE: begin
        if (take && !req.write) begin
          // Inactive channel or empty set: request taken, nothing sent.
          if (in_results && active[req_ch]) begin
            nxt_resp_valid = 1'b1;
            nxt_req_ready = 1'b0;
            nxt_resp_state = adc_access_pkg::RESP_SEND;
            nxt_rd_all = 1'b0;
            if (req_lower) begin
              // Upper captured with lower, so the pair is one result.
              nxt_resp = '{data: lower_q[req_ch], last: 1'b0};
              nxt_hold = upper_q[req_ch];
              nxt_rd_upper_next = 1'b1;
            end else begin
              nxt_resp = '{data: upper_q[req_ch], last: 1'b1};
            end
          end else if (is_all && (|active)) begin
            nxt_rd_ch = lowest(active);
            nxt_resp = '{data: lower_q[lowest(active)], last: 1'b0};
            nxt_hold = upper_q[lowest(active)];
            nxt_rd_upper_next = 1'b1;
            nxt_rd_all = 1'b1;
            nxt_resp_valid = 1'b1;
            nxt_req_ready = 1'b0;
            nxt_resp_state = adc_access_pkg::RESP_SEND;
          end
        end
      end
      adc_access_pkg::RESP_SEND: begin
        if (resp_ready) begin
          if (resp_ff.last) begin
            nxt_resp_valid = 1'b0;
            nxt_req_ready = 1'b1;
            nxt_resp_state = adc_access_pkg::RESP_IDLE;
          end else if (rd_upper_next_ff) begin
            nxt_resp = '{data: hold_ff, last: !rd_all_ff || !(|above)};
            nxt_rd_upper_next = 1'b0;
          end else begin
            nxt_rd_ch = lowest(above);
            nxt_resp = '{data: lower_q[lowest(above)], last: 1'b0};
            nxt_hold = upper_q[lowest(above)];
            nxt_rd_upper_next = 1'b1;
          end
        end
      end
      default: begin
        nxt_resp_state = adc_access_pkg::RESP_IDLE;
        nxt_resp_valid = 1'b0;
        nxt_req_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_state_ff <= adc_access_pkg::RESP_IDLE;
      rd_all_ff <= 1'b0;
      rd_upper_next_ff <= 1'b0;
      rd_ch_ff <= '0;
      hold_ff <= adc_access_pkg::RESULT_RESET;
      resp_valid_ff <= 1'b0;
      resp_ff <= '0;
      req_ready_ff <= 1'b1;
    end else begin
      resp_state_ff <= nxt_resp_state;
      rd_all_ff <= nxt_rd_all;
      rd_upper_next_ff <= nxt_rd_upper_next;
      rd_ch_ff <= nxt_rd_ch;
      hold_ff <= nxt_hold;
      resp_valid_ff <= nxt_resp_valid;
      resp_ff <= nxt_resp;
      req_ready_ff <= nxt_req_ready;
    end
  end

endmodule // adc_result_access

// ===== rtl/adc_access_pkg.sv
package adc_access_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int RES_W = 12;
  localparam int CH_W = 3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RESULT_BASE_ADDR = 8'h25;
  localparam logic [7:0] RESULT_LAST_ADDR = 8'h34;
  localparam logic [7:0] CONVERT_ALL_ADDR = 8'h35;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field layout of the two result bytes
  // ----------------------------------------------------------------
  localparam int UPPER_MSB = 11;
  localparam int UPPER_LSB = 4;
  localparam int LOWER_MSB = 3;
  localparam int LOWER_LSB = 0;
  localparam logic [3:0] LOWER_RESERVED = 4'h0;

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } resp_byte_t;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_WAIT = 2'b10
  } conv_state_t;

  typedef enum logic [1:0] {
    RESP_IDLE = 2'b01,
    RESP_SEND = 2'b10
  } resp_state_t;

endpackage

// ===== rtl/adc_result_slot.sv
`timescale 1ns/1ps

// One channel's pair of result bytes, updated in a single edge.
module adc_result_slot #(
  parameter int RES_W = adc_access_pkg::RES_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // New result
  input wire logic load,
  input wire logic [RES_W-1:0] result,
  // Stored bytes
  output logic [7:0] upper_ff,
  output logic [7:0] lower_ff
);

  logic [7:0] nxt_upper;
  logic [7:0] nxt_lower;

  always_comb begin
    nxt_upper = upper_ff;
    nxt_lower = lower_ff;
    if (load) begin
      // Both bytes change on one edge, so no reader sees half a result.
      nxt_upper = result[adc_access_pkg::UPPER_MSB:adc_access_pkg::UPPER_LSB];
      nxt_lower = {result[adc_access_pkg::LOWER_MSB:adc_access_pkg::LOWER_LSB],
                   adc_access_pkg::LOWER_RESERVED};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_ff <= adc_access_pkg::RESULT_RESET;
      lower_ff <= adc_access_pkg::RESULT_RESET;
    end else begin
      upper_ff <= nxt_upper;
      lower_ff <= nxt_lower;
    end
  end

endmodule // adc_result_slot

// ===== bench/adc_conv_model.sv
`timescale 1ns/1ps

// Converter stand-in: answers each start after a bench-chosen delay
module adc_conv_model (
  // Control
  input wire logic clk,
  input wire logic start,
  input wire logic [4:0] delay,
  // Result
  output logic done,
  output logic [11:0] result
);
  initial begin
    done = 1'b0;
    result = 12'hA5A;
    forever begin
      @(negedge clk);
      if (start === 1'b1) begin
        repeat (delay) @(negedge clk);
        // Non-blocking, so the bench monitor on the same edge never races the pulse
        done <= 1'b1;
        result <= 12'($urandom);
        @(negedge clk);
        done <= 1'b0;
        // Result is only valid with done, so it is not left standing
        result <= ~result;
      end
    end
  end
endmodule // adc_conv_model

// ===== bench/adc_result_access_chk.sv
`timescale 1ns/1ps

module adc_result_access_chk #(
  parameter int NUM_CH = 8,
  parameter int RES_W = 12
) (
  // Watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire adc_access_pkg::reg_req_t req,
  input wire logic req_ready_ff,
  input wire logic resp_valid_ff,
  input wire adc_access_pkg::resp_byte_t resp_ff,
  input wire logic resp_ready,
  input wire logic [NUM_CH-1:0] io_direction,
  input wire logic [NUM_CH-1:0] io_function,
  input wire logic conv_start_ff,
  input wire logic [adc_access_pkg::CH_W-1:0] conv_channel_ff,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result
);
  logic [7:0] offs;
  logic in_res;
  logic hit;
  logic busy_ff;
  logic nxt_busy;
  assign offs = req.addr - adc_access_pkg::RESULT_BASE_ADDR;
  assign in_res = offs < 8'h10;
  assign hit = in_res && io_direction[offs[3:1]] && io_function[offs[3:1]];
  always_comb begin
    nxt_busy = conv_start_ff | (busy_ff & ~conv_done);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busy_ff <= 1'b0;
    else busy_ff <= nxt_busy;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd;
    req_valid && req_ready_ff && !req.write;
  endsequence
  // Quiet converter: nothing may still be pending behind a done or a write just taken
  sequence s_wr_idle;
    req_valid && req_ready_ff && req.write && !busy_ff && !conv_start_ff &&
    !$past(conv_done) && !$past(req_valid && req_ready_ff && req.write);
  endsequence

  a_upper_one: assert property (s_rd ##0 (hit && !offs[0])
    |=> resp_valid_ff && resp_ff.last) else $error("upper read not one byte");
  a_lower_two: assert property (s_rd ##0 (hit && offs[0])
    |=> resp_valid_ff && !resp_ff.last && resp_ff.data[3:0] == 4'h0)
    else $error("lower read not lower byte first");
  a_silent_idle: assert property (s_rd ##0 (in_res && !hit)
    |=> !resp_valid_ff && req_ready_ff) else $error("inactive channel answered");
  a_hold_byte: assert property (resp_valid_ff && !resp_ready
    |=> resp_valid_ff && $stable(resp_ff)) else $error("byte dropped while stalled");
  a_busy_refuse: assert property (resp_valid_ff |-> !req_ready_ff)
    else $error("request taken while streaming");
  a_end_msg: assert property (resp_valid_ff && resp_ready && resp_ff.last
    |=> !resp_valid_ff && req_ready_ff) else $error("stream not closed");
  a_start_chan: assert property (s_wr_idle ##0 hit
    |-> ##2 conv_start_ff && conv_channel_ff == $past(offs[3:1], 2)) else $error("no start");
  a_all_start: assert property (s_wr_idle ##0 (req.addr == 8'h35)
    ##0 (|(io_direction & io_function)) |-> ##2 conv_start_ff) else $error("no sweep");
  a_one_conv: assert property (busy_ff |-> !conv_start_ff)
    else $error("start while converting");
  a_chan_hold: assert property (busy_ff && !conv_done |=> $stable(conv_channel_ff))
    else $error("channel moved mid conversion");
endmodule // adc_result_access_chk

bind adc_result_access adc_result_access_chk #(.NUM_CH(NUM_CH), .RES_W(RES_W)) u_chk (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready_ff(req_ready_ff),
  .resp_valid_ff(resp_valid_ff), .resp_ff(resp_ff), .resp_ready(resp_ready),
  .io_direction(io_direction), .io_function(io_function), .conv_start_ff(conv_start_ff),
  .conv_channel_ff(conv_channel_ff), .conv_done(conv_done), .conv_result(conv_result));

// ===== bench/adc_result_access_test.sv
`timescale 1ns/1ps

module adc_result_access_test;
  typedef logic [7:0] bq_t[$];
  logic clk, rst, req_valid, resp_ready, conv_start_ff, conv_done, req_ready_ff;
  logic resp_valid_ff;
  adc_access_pkg::reg_req_t req;
  adc_access_pkg::resp_byte_t resp_ff;
  logic [7:0] io_direction, io_function, act, a;
  logic [2:0] conv_channel_ff, c;
  logic [11:0] conv_result;
  logic [11:0] expr[8];
  logic [4:0] delay;
  int n_fail, checks, nd, j;
  bq_t got, strt;

  adc_result_access DUT (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready_ff(req_ready_ff), .resp_valid_ff(resp_valid_ff), .resp_ff(resp_ff),
    .resp_ready(resp_ready), .io_direction(io_direction), .io_function(io_function),
    .conv_start_ff(conv_start_ff), .conv_channel_ff(conv_channel_ff),
    .conv_done(conv_done), .conv_result(conv_result));
  adc_conv_model conv (.clk(clk), .start(conv_start_ff), .delay(delay), .done(conv_done),
    .result(conv_result));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk) begin
    if (conv_start_ff === 1'b1) strt.push_back({5'h00, conv_channel_ff});
    if (conv_done === 1'b1) begin
      expr[conv_channel_ff] = conv_result;
      nd++;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Request held from a falling edge until the edge that takes it
  task automatic send(input logic w, input logic [7:0] ad);
    req = '{write: w, addr: ad, data: 8'($urandom)};
    req_valid = 1'b1;
    for (int k = 0; k < 50 && req_ready_ff !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  function automatic bq_t want(input logic [7:0] ad);
    bq_t q;
    q = {};
    for (int i = 0; i < 8; i++) begin
      if (act[i] && (ad == 8'h35 || (ad - 8'h25) >> 1 == 8'(i))) begin
        if (ad == 8'h35 || !ad[0]) q.push_back({expr[i][3:0], 4'h0});
        q.push_back(expr[i][11:4]);
      end
    end
    return q;
  endfunction

  task automatic cmp_rd(input logic [7:0] ad);
    bq_t w;
    w = want(ad);
    got = {};
    send(1'b0, ad);
    for (int k = 0; k < 40; k++) begin
      resp_ready = 1'(($urandom % 4) != 0);
      if (resp_valid_ff === 1'b1 && resp_ready) begin
        got.push_back(resp_ff.data);
        if (resp_ff.last === 1'b1) k = 40;
      end
      @(negedge clk);
    end
    check(8'(got.size()), 8'(w.size()));
    foreach (w[i]) check(got[i], w[i]);
  endtask

  task automatic settle(input int n);
    for (int k = 0; k < 400 && nd < n; k++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] ad);
    nd = 0;
    strt = {};
    send(1'b1, ad);
  endtask

  initial begin
    #2000000;
    n_fail++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    resp_ready = 1'b0;
    io_direction = 8'hF0;
    io_function = 8'h43;
    delay = 5'd3;
    foreach (expr[i]) expr[i] = 12'h000;
    void'($urandom(82541));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    act = io_direction & io_function;
    cmp_rd(8'h32);
    for (int r = 0; r < 7; r++) begin
      case (r)
        0: begin io_direction = 8'hFF; io_function = 8'hFF; end
        1: begin io_direction = 8'h89; io_function = 8'hFF; end
        2: begin io_direction = 8'hFF; io_function = 8'h00; end
        default: begin io_direction = 8'($urandom); io_function = 8'($urandom); end
      endcase
      act = io_direction & io_function;
      delay = 5'(1 + $urandom % 6);
      wr(8'h35);
      settle($countones(act));
      j = 0;
      for (int k = 0; k < 8; k++) begin
        if (act[k]) begin
          check(strt[j], 8'(k));
          j++;
        end
      end
      check(8'(strt.size()), 8'($countones(act)));
      c = 3'($urandom);
      wr(8'h25 + {4'h0, c, 1'b0} + 8'(r % 2));
      settle(act[c]);
      check(8'(strt.size()), {7'h00, act[c]});
      if (act[c]) check(strt[0], {5'h00, c});
      cmp_rd(8'h35);
      for (a = 8'h24; a <= 8'h36; a++) cmp_rd(a);
      $display("round %0d finished", r);
    end
    io_direction = 8'hFF;
    io_function = 8'hFF;
    act = 8'hFF;
    wr(8'h36);
    settle(0);
    check(8'(strt.size()), 8'h00);
    delay = 5'd25;
    wr(8'h27);
    settle(0);
    cmp_rd(8'h28);
    settle(1);
    cmp_rd(8'h28);
    $display("slow conversion test finished");
    test_done();
  end
endmodule // adc_result_access_test
